// *** logic/cpc_defines.svh ***
// Register offsets, field positions, reset values and timing counts of the pin control block
`ifndef CPC_DEFINES_SVH
`define CPC_DEFINES_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define CPC_OFF_PIN_CTRL     8'h00
`define CPC_OFF_SAMPLE_CTRL  8'h04
`define CPC_OFF_PRESCALER    8'h08
`define CPC_OFF_PHASE_SEG    8'h0c
`define CPC_OFF_TIMER        8'h10
`define CPC_OFF_IRQ_STATUS   8'h14
`define CPC_OFF_IRQ_MASK     8'h18

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define CPC_BUSOFF_MASK_BIT  7
`define CPC_ERROR_MASK_BIT   6
`define CPC_RX_POL_BIT       2
`define CPC_TX_MODE_HI       1
`define CPC_TX_MODE_LO       0
`define CPC_TRIPLE_BIT       7
`define CPC_RSVD_BIT         6
`define CPC_TIMER_SYNC_ENABLE_BIT        5
`define CPC_ORDER_BIT        4
`define CPC_LISTEN_BIT       3
`define CPC_PROP_HI          2
`define CPC_PSEG1_HI         5
`define CPC_PSEG1_LO         3
`define CPC_PSEG2_HI         2
`define CPC_STAT_BUSOFF      1
`define CPC_STAT_ERROR       0

// ---------------------------------------------------------------
// Writable bit masks and reset values
// ---------------------------------------------------------------
`define CPC_PIN_CTRL_WMASK   8'hc7
`define CPC_SAMPLE_WMASK     8'hbf
`define CPC_RST_PIN_CTRL     8'h00
`define CPC_RST_SAMPLE_CTRL  8'h00
`define CPC_RST_PRESCALER    8'h00
`define CPC_RST_PHASE_SEG    8'h00
`define CPC_RST_TIMER        16'h0000
`define CPC_TIMER_MAX        16'hffff

// ---------------------------------------------------------------
// Bus answers and sizes
// ---------------------------------------------------------------
`define CPC_RESP_OKAY        2'b00
`define CPC_RESP_SLVERR      2'b10
`define CPC_TX_BUFS          4
`define CPC_ID_W             11

`endif

// *** logic/cpc_pin_timing.sv ***
// Pin polarity, transmit drive, sampling, bit timing and free-running timer of a CAN node
//
// Contract
// - Bus-off interrupt forwarded only when mask set
// - Error interrupt forwarded only when mask set
// - Receive polarity bit selects dominant pin level
// - Mode 00 drives both levels, 0 dominant
// - Mode 01 drives both levels, 1 dominant
// - Mode 1x drives dominant only, else released
// - Open drain forces positive polarity
// - Single sample at end of phase segment 1
// - Triple sample: sample point plus two before
// - Timer sync resets timer on buffer 0 receive
// - Order bit: lowest identifier or lowest buffer
// - Listen-only receives but never drives the bus
// - Propagation segment lasts field plus one quanta
// - One time quantum is one serial clock
// - Serial clock is system clock over 2(p+1)
// - Timer starts at zero, counts, wraps at max
`timescale 1ns/1ns

`include "cpc_defines.svh"

module cpc_pin_timing
  import cpc_pkg::*;
(
  input  wire logic                              clock,
  input  wire logic                              srst,
  input  wire logic                              ce,
  // AXI4-Lite slave
  input  wire logic [7:0]                        s_axi_awaddr,
  input  wire logic                              s_axi_awvalid,
  output logic                                   s_axi_awready,
  input  wire logic [31:0]                       s_axi_wdata,
  input  wire logic [3:0]                        s_axi_wstrb,
  input  wire logic                              s_axi_wvalid,
  output logic                                   s_axi_wready,
  output logic [1:0]                             s_axi_bresp,
  output logic                                   s_axi_bvalid,
  input  wire logic                              s_axi_bready,
  input  wire logic [7:0]                        s_axi_araddr,
  input  wire logic                              s_axi_arvalid,
  output logic                                   s_axi_arready,
  output logic [31:0]                            s_axi_rdata,
  output logic [1:0]                             s_axi_rresp,
  output logic                                   s_axi_rvalid,
  input  wire logic                              s_axi_rready,
  // Protocol core side
  input  wire logic                              busoff_event,
  input  wire logic                              error_event,
  input  wire logic                              rx_mb0_event,
  input  wire logic                              tx_dominant,
  input  wire logic [`CPC_TX_BUFS-1:0]           tx_pending,
  input  wire logic [`CPC_TX_BUFS*`CPC_ID_W-1:0] tx_ids,
  output logic [1:0]                             tx_select,
  output logic                                   tx_select_valid,
  output logic                                   rx_bit,
  output logic                                   rx_bit_valid,
  output logic                                   bit_tick,
  output logic [15:0]                            free_timer,
  output logic                                   irq,
  // Transceiver pins
  input  wire logic                              can_receive_pin,
  output logic                                   can_transmit_pin_o,
  output logic                                   can_transmit_pin_oe
);

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  function automatic logic [7:0] merge_byte(input logic [7:0] old_v, input logic [7:0] new_v,
                                            input logic strb, input logic [7:0] wmask);
    merge_byte = strb ? ((old_v & ~wmask) | (new_v & wmask)) : old_v;
  endfunction

  function automatic logic majority(input logic [2:0] s);
    majority = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  function automatic logic [31:0] read_reg(input logic [7:0] a, input cpc_state_type s);
    read_reg = 32'h0000_0000;
    case (a)
      `CPC_OFF_PIN_CTRL:    read_reg = {24'h00_0000, s.pin_ctrl};
      `CPC_OFF_SAMPLE_CTRL: read_reg = {24'h00_0000, s.sample_ctrl};
      `CPC_OFF_PRESCALER:   read_reg = {24'h00_0000, s.prescaler};
      `CPC_OFF_PHASE_SEG:   read_reg = {24'h00_0000, s.phase_seg};
      `CPC_OFF_TIMER:       read_reg = {16'h0000, s.timer};
      `CPC_OFF_IRQ_STATUS:  read_reg = {30'h0000_0000, s.status};
      `CPC_OFF_IRQ_MASK:    read_reg = {30'h0000_0000, s.imask};
      default:              read_reg = 32'h0000_0000;
    endcase
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    case (a)
      `CPC_OFF_PIN_CTRL,
      `CPC_OFF_SAMPLE_CTRL,
      `CPC_OFF_PRESCALER,
      `CPC_OFF_PHASE_SEG,
      `CPC_OFF_TIMER,
      `CPC_OFF_IRQ_STATUS,
      `CPC_OFF_IRQ_MASK:    is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  cpc_state_type q;
  cpc_state_type d;

  // ---------------------------------------------------------------
  // Next-state helpers
  // ---------------------------------------------------------------
  // Bus decode
  logic       do_write;
  logic       do_read;
  logic [7:0] wa;
  logic [1:0] st_clr;
  logic [1:0] st_set;
  // Bit timing
  logic       rx_level;
  logic       tq_tick;
  logic [4:0] sp_idx;
  logic [4:0] end_idx;
  // Transmit
  logic       tx_dom;
  logic       triple;
  logic [`CPC_ID_W-1:0] best_id;
  logic [`CPC_ID_W-1:0] cur_id;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    d = q;

    // ----------------------------
    // Bus handshake
    // ----------------------------
    // Address and data taken in either order, answer after both
    do_write = q.aw_v && q.w_v && !q.b_v;
    wa       = q.aw_addr;
    if (s_axi_awvalid && !q.aw_v && !q.b_v) begin
      d.aw_v    = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q.w_v && !q.b_v) begin
      d.w_v    = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
    end
    st_clr = 2'b00;
    if (do_write) begin
      d.aw_v   = 1'b0;
      d.w_v    = 1'b0;
      d.b_v    = 1'b1;
      d.b_resp = is_mapped(wa) ? `CPC_RESP_OKAY : `CPC_RESP_SLVERR;
      case (wa)
        `CPC_OFF_PIN_CTRL:
          d.pin_ctrl = merge_byte(q.pin_ctrl, q.w_data[7:0], q.w_strb[0], `CPC_PIN_CTRL_WMASK);
        // Reserved bit is held at zero whatever software writes
        `CPC_OFF_SAMPLE_CTRL:
          d.sample_ctrl = merge_byte(q.sample_ctrl, q.w_data[7:0], q.w_strb[0],
                                     `CPC_SAMPLE_WMASK);
        `CPC_OFF_PRESCALER:
          d.prescaler = merge_byte(q.prescaler, q.w_data[7:0], q.w_strb[0], 8'hff);
        `CPC_OFF_PHASE_SEG:
          d.phase_seg = merge_byte(q.phase_seg, q.w_data[7:0], q.w_strb[0], 8'hff);
        `CPC_OFF_TIMER: begin
          d.timer[7:0]  = merge_byte(q.timer[7:0], q.w_data[7:0], q.w_strb[0], 8'hff);
          d.timer[15:8] = merge_byte(q.timer[15:8], q.w_data[15:8], q.w_strb[1], 8'hff);
        end
        `CPC_OFF_IRQ_STATUS:
          st_clr = q.w_strb[0] ? q.w_data[1:0] : 2'b00;
        `CPC_OFF_IRQ_MASK:
          d.imask = q.w_strb[0] ? q.w_data[1:0] : q.imask;
        default: d.b_resp = `CPC_RESP_SLVERR;
      endcase
    end
    if (q.b_v && s_axi_bready) begin
      d.b_v = 1'b0;
    end
    // Read answer is registered; arready stays low until it is taken
    do_read = s_axi_arvalid && !q.r_v;
    if (do_read) begin
      d.r_v    = 1'b1;
      d.r_data = read_reg(s_axi_araddr, q);
      d.r_resp = is_mapped(s_axi_araddr) ? `CPC_RESP_OKAY : `CPC_RESP_SLVERR;
    end else if (q.r_v && s_axi_rready) begin
      d.r_v = 1'b0;
    end

    // ----------------------------
    // Interrupts
    // ----------------------------
    // Sticky events; a set in the clearing cycle wins
    st_set   = {busoff_event, error_event};
    d.status = (q.status & ~st_clr) | st_set;
    d.irq    = (q.status[`CPC_STAT_BUSOFF] & q.imask[`CPC_STAT_BUSOFF]
                & q.pin_ctrl[`CPC_BUSOFF_MASK_BIT])
             | (q.status[`CPC_STAT_ERROR] & q.imask[`CPC_STAT_ERROR]
                & q.pin_ctrl[`CPC_ERROR_MASK_BIT]);

    // ----------------------------
    // Receive pin
    // ----------------------------
    // Two flops, then polarity; logical 0 means dominant
    d.rx_s1  = can_receive_pin;
    d.rx_s2  = q.rx_s1;
    rx_level = q.pin_ctrl[`CPC_RX_POL_BIT] ? ~q.rx_s2 : q.rx_s2;

    // ----------------------------
    // Serial clock
    // ----------------------------
    // Serial clock tick every 2(p+1) system clocks
    tq_tick = (q.presc_cnt == {q.prescaler, 1'b1});
    d.presc_cnt = tq_tick ? 9'h000 : q.presc_cnt + 9'h001;

    // ----------------------------
    // Bit timing
    // ----------------------------
    // Bit time in quanta: sync, propagation, phase 1, phase 2
    // A shortened bit wraps the counter instead of sticking
    sp_idx  = 5'h02 + {2'b00, q.sample_ctrl[`CPC_PROP_HI:0]}
            + {2'b00, q.phase_seg[`CPC_PSEG1_HI:`CPC_PSEG1_LO]};
    end_idx = sp_idx + 5'h01 + {2'b00, q.phase_seg[`CPC_PSEG2_HI:0]};
    triple  = q.sample_ctrl[`CPC_TRIPLE_BIT];
    d.rx_valid = 1'b0;
    d.bit_tick = 1'b0;
    // Each quantum counts one serial clock
    if (tq_tick) begin
      d.smp    = {q.smp[0], rx_level};
      d.tq_cnt = (q.tq_cnt == end_idx) ? 5'h00 : q.tq_cnt + 5'h01;
      if (q.tq_cnt == end_idx) begin
        d.bit_tick = 1'b1;
      end
      if (q.tq_cnt == sp_idx) begin
        d.rx_valid = 1'b1;
        if (triple) begin
          d.rx_bit = majority({q.smp, rx_level});
        end else begin
          d.rx_bit = rx_level;
        end
      end
    end

    // ----------------------------
    // Free-running timer
    // ----------------------------
    // Sync reset takes precedence over count and write
    if (q.bit_tick) begin
      d.timer = (q.timer == `CPC_TIMER_MAX) ? 16'h0000 : q.timer + 16'h0001;
    end
    if (do_write && wa == `CPC_OFF_TIMER) begin
      d.timer[7:0]  = merge_byte(q.timer[7:0], q.w_data[7:0], q.w_strb[0], 8'hff);
      d.timer[15:8] = merge_byte(q.timer[15:8], q.w_data[15:8], q.w_strb[1], 8'hff);
    end
    if (q.sample_ctrl[`CPC_TIMER_SYNC_ENABLE_BIT] && rx_mb0_event) begin
      d.timer = `CPC_RST_TIMER;
    end

    // ----------------------------
    // Transmit drive
    // ----------------------------
    // Listen-only blocks every dominant bit, acknowledge included
    tx_dom = tx_dominant && !q.sample_ctrl[`CPC_LISTEN_BIT];
    if (q.sample_ctrl[`CPC_LISTEN_BIT]) begin
      d.tx_pin = 1'b1;
      d.tx_oe  = 1'b0;
    end else if (q.pin_ctrl[`CPC_TX_MODE_HI]) begin
      d.tx_pin = 1'b0;
      d.tx_oe  = tx_dom;
    end else if (q.pin_ctrl[`CPC_TX_MODE_LO]) begin
      d.tx_pin = tx_dom;
      d.tx_oe  = 1'b1;
    end else begin
      d.tx_pin = ~tx_dom;
      d.tx_oe  = 1'b1;
    end

    // ----------------------------
    // Transmit order
    // ----------------------------
    // First pending buffer wins ties, so lowest number also breaks equal ids
    d.tx_sel_v = |tx_pending;
    d.tx_sel   = 2'b00;
    best_id    = {`CPC_ID_W{1'b1}};
    cur_id     = {`CPC_ID_W{1'b1}};
    for (int i = `CPC_TX_BUFS - 1; i >= 0; i--) begin
      cur_id = tx_ids[i*`CPC_ID_W +: `CPC_ID_W];
      if (tx_pending[i]) begin
        if (q.sample_ctrl[`CPC_ORDER_BIT] || cur_id <= best_id) begin
          d.tx_sel = 2'(i);
          best_id  = cur_id;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      q             <= '0;
      q.pin_ctrl    <= `CPC_RST_PIN_CTRL;
      q.sample_ctrl <= `CPC_RST_SAMPLE_CTRL;
      q.prescaler   <= `CPC_RST_PRESCALER;
      q.phase_seg   <= `CPC_RST_PHASE_SEG;
      q.timer       <= `CPC_RST_TIMER;
      // Pin flops start recessive so no false edge follows reset
      q.tx_pin      <= 1'b1;
      q.rx_s1       <= 1'b1;
      q.rx_s2       <= 1'b1;
      q.rx_bit      <= 1'b1;
    end else if (ce) begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Ready only when idle, so a held request is never lost while frozen
  assign s_axi_awready       = ce && !q.aw_v && !q.b_v;
  assign s_axi_wready        = ce && !q.w_v && !q.b_v;
  assign s_axi_bvalid        = q.b_v;
  assign s_axi_bresp         = q.b_resp;
  assign s_axi_arready       = ce && !q.r_v;
  assign s_axi_rvalid        = q.r_v;
  assign s_axi_rdata         = q.r_data;
  assign s_axi_rresp         = q.r_resp;
  assign tx_select           = q.tx_sel;
  assign tx_select_valid     = q.tx_sel_v;
  assign rx_bit              = q.rx_bit;
  assign rx_bit_valid        = q.rx_valid;
  assign bit_tick            = q.bit_tick;
  assign free_timer          = q.timer;
  assign irq                 = q.irq;
  assign can_transmit_pin_o  = q.tx_pin;
  assign can_transmit_pin_oe = q.tx_oe;

endmodule

// *** logic/cpc_pkg.sv ***
// Types of the pin and bit timing control block
package cpc_pkg;

  // ---------------------------------------------------------------
  // Complete register state of the block
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        aw_v;
    logic [7:0]  aw_addr;
    logic        w_v;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        b_v;
    logic [1:0]  b_resp;
    logic        r_v;
    logic [31:0] r_data;
    logic [1:0]  r_resp;
    logic [7:0]  pin_ctrl;
    logic [7:0]  sample_ctrl;
    logic [7:0]  prescaler;
    logic [7:0]  phase_seg;
    logic [1:0]  status;
    logic [1:0]  imask;
    logic        irq;
    logic        rx_s1;
    logic        rx_s2;
    logic [8:0]  presc_cnt;
    logic [4:0]  tq_cnt;
    logic [1:0]  smp;
    logic        rx_bit;
    logic        rx_valid;
    logic        bit_tick;
    logic [15:0] timer;
    logic        tx_pin;
    logic        tx_oe;
    logic [1:0]  tx_sel;
    logic        tx_sel_v;
  } cpc_state_type;

endpackage

// *** verification/cpc_can_bus_model.sv ***
// Transceiver and remote node on the CAN wire
`timescale 1ns/1ns
module cpc_can_bus_model (
  input  wire logic tx_o,
  input  wire logic tx_oe,
  input  wire logic remote_dominant,
  output logic      rx_pin
);
  // A released driver leaves the wire to the recessive pull-up
  assign rx_pin = !((tx_oe && !tx_o) || remote_dominant);
endmodule

// *** verification/cpc_pin_timing_props.sv ***
// Port-level assertions for the pin and bit timing block
`timescale 1ns/1ns
module cpc_pin_timing_props (
  input wire logic        clock,
  input wire logic        srst,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        rx_mb0_event,
  input wire logic        tx_dominant,
  input wire logic        bit_tick,
  input wire logic [15:0] free_timer,
  input wire logic        irq,
  input wire logic        can_transmit_pin_o,
  input wire logic        can_transmit_pin_oe
);
  // ---------------------------------------------------------------
  // Control register shadows
  // ---------------------------------------------------------------
  // One cycle behind the real registers, which lines them up with registered outputs
  logic [7:0] aw_q, wd_q, pc_q, sc_q;
  logic       bv_q, live_q;
  always_ff @(posedge clock) begin
    if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata[7:0];
    bv_q <= s_axi_bvalid;
    live_q <= !srst;
    if (srst) pc_q <= 8'h00;
    else if (s_axi_bvalid && !bv_q && aw_q == 8'h00) pc_q <= wd_q & 8'hc7;
    if (srst) sc_q <= 8'h00;
    else if (s_axi_bvalid && !bv_q && aw_q == 8'h04) sc_q <= wd_q & 8'hbf;
  end
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  sequence s_bit_gap;
    !bit_tick [*7];
  endsequence
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  property p_drive_pos;
    live_q && pc_q[1:0] == 2'b00 && !sc_q[3]
      |-> can_transmit_pin_oe && can_transmit_pin_o == !$past(tx_dominant);
  endproperty
  property p_drive_neg;
    live_q && pc_q[1:0] == 2'b01 && !sc_q[3]
      |-> can_transmit_pin_oe && can_transmit_pin_o == $past(tx_dominant);
  endproperty
  property p_open_drain;
    live_q && pc_q[1] && !sc_q[3]
      |-> !can_transmit_pin_o && can_transmit_pin_oe == $past(tx_dominant);
  endproperty
  property p_listen;
    live_q && sc_q[3] |-> !can_transmit_pin_oe && can_transmit_pin_o;
  endproperty
  property p_irq_mask;
    irq |-> pc_q[7] || pc_q[6];
  endproperty
  property p_timer_sync_enable;
    live_q && sc_q[5] && rx_mb0_event |-> ##[1:2] free_timer == 16'h0000;
  endproperty
  property p_tick_gap;
    bit_tick |=> s_bit_gap;
  endproperty
  property p_wr_busy;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  property p_rd_busy;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  property p_wr_answer;
    s_wr_taken |-> ##[1:3] s_axi_bvalid;
  endproperty
  a_drive_pos: assert property (p_drive_pos)
    else $error("positive drive wrong");
  a_drive_neg: assert property (p_drive_neg)
    else $error("negative drive wrong");
  a_open_drain: assert property (p_open_drain)
    else $error("open drain drive wrong");
  a_listen: assert property (p_listen)
    else $error("listen-only drives the bus");
  a_irq_mask: assert property (p_irq_mask)
    else $error("interrupt passed a closed mask");
  a_timer_sync_enable: assert property (p_timer_sync_enable)
    else $error("timer not zeroed on sync");
  a_tick_gap: assert property (p_tick_gap)
    else $error("bit time too short");
  a_wr_busy: assert property (p_wr_busy)
    else $error("write taken while answer pending");
  a_rd_busy: assert property (p_rd_busy)
    else $error("read taken while answer pending");
  a_wr_answer: assert property (p_wr_answer)
    else $error("write answer late");
endmodule

bind cpc_pin_timing cpc_pin_timing_props cpc_pin_timing_props_inst (.*);

// *** verification/cpc_pin_timing_tb.sv ***
// Self-checking bench for the pin and bit timing block
`timescale 1ns/1ns
module cpc_pin_timing_tb;
  logic        clock = 1'b0, srst = 1'b1, ce = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, v;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf, tx_pending = 4'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, rx_mb0_event = 1'b0;
  logic        busoff_event = 1'b0, error_event = 1'b0, tx_dominant = 1'b0;
  logic        remote_dom = 1'b0, r;
  logic [43:0] tx_ids = 44'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, tx_select;
  logic [15:0] free_timer;
  logic        tx_select_valid, rx_bit, rx_bit_valid, bit_tick, irq, can_receive_pin;
  logic        can_transmit_pin_o, can_transmit_pin_oe;
  logic [33:0] exp_q[$];
  int          error_cnt = 0, checked = 0, cycles = 0, n, p, q, pr;

  cpc_pin_timing cpc_pin_timing_inst (.*);
  cpc_can_bus_model cpc_can_bus_model_inst (.tx_o(can_transmit_pin_o),
    .tx_oe(can_transmit_pin_oe), .remote_dominant(remote_dom), .rx_pin(can_receive_pin));

  always #20 clock = !clock;
  // ---------------------------------------------------------------
  // Checking, bus tasks and closing
  // ---------------------------------------------------------------
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'b0;
    chk({32'h0, s_axi_bresp}, {32'h0, er});
    @(posedge clock);
  endtask
  // Read result is compared by the monitor below when the data arrives
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wait_tick();
    do @(posedge clock); while (bit_tick !== 1'b1);
  endtask
  always @(posedge clock) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) chk({s_axi_rresp, s_axi_rdata},
      exp_q.pop_front());
    cycles++;
    if (cycles > 60000) begin
      error_cnt++;
      conclude();
    end
  end
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'h0378));
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    for (int i = 0; i < 7; i++) if (i != 4) rd(8'(4 * i), 34'h0);
    rd(8'h1c, {2'b10, 32'h0});
    wr(8'h1c, 32'hff, 2'b10);
    v = 8'($urandom);
    wr(8'h00, {24'h0, v}, 2'b00);
    rd(8'h00, {26'h0, v & 8'hc7});
    v = 8'($urandom) & 8'hbf;
    wr(8'h04, {24'h0, v}, 2'b00);
    rd(8'h04, {26'h0, v});
    // Every drive mode with both bus levels, then listen-only over a dominant request
    wr(8'h04, 32'h0, 2'b00);
    for (int m = 0; m < 4; m++) begin
      wr(8'h00, m, 2'b00);
      for (int d = 0; d < 2; d++) begin
        tx_dominant <= d[0];
        repeat (3) @(posedge clock);
        chk({32'h0, can_transmit_pin_oe, can_transmit_pin_o}, {32'h0, m[1] ? d[0] : 1'b1,
          m[1] ? 1'b0 : (m[0] ? d[0] : !d[0])});
      end
    end
    wr(8'h04, 32'h08, 2'b00);
    repeat (3) @(posedge clock);
    chk({32'h0, can_transmit_pin_oe, can_transmit_pin_o}, 34'h1);
    tx_dominant <= 1'b0;
    // Sticky events, pin-control masks, interrupt mask and one-to-clear
    wr(8'h18, 32'h3, 2'b00);
    for (int k = 0; k < 2; k++) begin
      wr(8'h00, 32'h0, 2'b00);
      {busoff_event, error_event} <= 2'b10 >> k;
      @(posedge clock);
      {busoff_event, error_event} <= 2'b00;
      repeat (3) @(posedge clock);
      chk({33'h0, irq}, 34'h0);
      rd(8'h14, 34'h2 >> k);
      wr(8'h00, 32'h80 >> k, 2'b00);
      repeat (2) @(posedge clock);
      chk({33'h0, irq}, 34'h1);
      wr(8'h14, 32'h2 >> k, 2'b00);
      repeat (2) @(posedge clock);
      chk({33'h0, irq}, 34'h0);
    end
    // Receive polarity with single and triple sampling
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, {29'h0, i[1], 2'b00}, 2'b00);
      wr(8'h04, {24'h0, i[0], 7'h00}, 2'b00);
      r = 1'($urandom);
      remote_dom <= r;
      repeat (2) do @(posedge clock); while (rx_bit_valid !== 1'b1);
      chk({33'h0, rx_bit}, {33'h0, i[1] ? r : !r});
    end
    remote_dom <= 1'b0;
    // Bit time from prescaler, propagation and phase segments
    for (int t = 0; t < 4; t++) begin
      p = (t == 0) ? 255 : $urandom_range(3);
      q = (t == 0) ? 0 : $urandom_range(63);
      pr = (t == 0) ? 0 : $urandom_range(7);
      wr(8'h08, p, 2'b00);
      wr(8'h0c, q, 2'b00);
      wr(8'h04, pr, 2'b00);
      wait_tick();
      wait_tick();
      n = 0;
      do begin
        @(posedge clock);
        n++;
      end while (bit_tick !== 1'b1);
      chk(34'(n), 34'(2 * (p + 1) * (4 + pr + q / 8 + q % 8)));
    end
    // Timer wrap, then synchronisation on a buffer 0 receive
    wr(8'h08, 32'h20, 2'b00);
    wait_tick();
    wr(8'h10, 32'hffff, 2'b00);
    wait_tick();
    @(posedge clock);
    chk({18'h0, free_timer}, 34'h0);
    for (int s = 1; s >= 0; s--) begin
      wr(8'h04, s ? 32'h20 : 32'h0, 2'b00);
      wr(8'h10, 32'h1234, 2'b00);
      rx_mb0_event <= 1'b1;
      @(posedge clock);
      rx_mb0_event <= 1'b0;
      @(posedge clock);
      chk({33'h0, free_timer === 16'h0}, {33'h0, s[0]});
    end
    // Transmit order: lowest identifier against lowest buffer number
    tx_ids <= {11'h7ff, 11'($urandom_range(1023)), 11'h400 | 11'($urandom), 11'h000};
    tx_pending <= 4'b0110;
    for (int o = 0; o < 2; o++) begin
      wr(8'h04, o ? 32'h10 : 32'h0, 2'b00);
      repeat (3) @(posedge clock);
      chk({31'h0, tx_select_valid, tx_select}, o ? 34'h5 : 34'h6);
    end
    conclude();
  end
endmodule
